// ===== strap_capture.sv
// Strap capture at reset release and wake-event output driver
`timescale 1ns/100ps
`include "strap_capture_cfg.svh"
// What this block does
// - The wake output asserts whenever a wake-on-LAN event is detected.
// - The wake output may be routed to any one of the general-purpose pins.
// - The routed pin drives push-pull or open-drain per its buffer-type bit.
// - The wake output's active level follows the wake-polarity control bit.
// - The integrated-jack strap selects normal (0) or jack presets (1).
// - A three-bit management address 0 to 7h is captured from its straps.
// - Each LED strap of 0 sets polarity 1, and a strap of 1 sets polarity 0.
// - Broadcast strap 0 accepts address 0 and own address, 1 only own.
// - The broadcast enable bit loads the inverse of the broadcast strap.
// - Five device-mode straps are latched as a five-bit mode code.
// - The reference-clock strap disables (0) or enables (1) its output.
// - The LED-style strap selects tri-color (0) or individual (1) LEDs.
// - All straps are latched as the chip reset is released.

// Timing after the reset input falls, counted in enabled clock edges:
//    edge 1: the sequencer moves from its reset state to sampling
//    edge 2: the synchronised straps land in the configuration outputs
//            and the valid flag rises; both hold until the next reset
//    edge 3: LED, GPIO and wake pins begin to drive
// The strap synchroniser keeps running through reset, so the pins must
// sit at their resistor levels for two edges before release; the sample
// from the last edge before release is what lands at edge 2, and a strap that moves after release is ignored.
// The wake output trails its event input by three edges: two for the
// synchroniser and one for the output flop.
// Each LED polarity is its strap inverted, so a strap made by an LED to
// ground comes up as an active-high LED.
// Selector value 7 routes the wake output to no GPIO at all; the
// dedicated pin has no buffer-type bit and always drives push-pull.
// Clock enable low freezes every flop, the synchronisers included.
module strap_capture
   import strap_capture_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire strap_bits_t strap_pins_in,
   input wire logic wake_event_in,
   input wire logic wake_polarity_in,
   input wire logic wake_route_dedicated_in,
   input wire logic [`WAKE_SEL_W-1:0] wake_gpio_sel_in,
   input wire logic [`GPIO_COUNT-1:0] gpio_open_drain_in,
   input wire logic [`GPIO_COUNT-1:0] gpio_out_in,
   input wire logic [`GPIO_COUNT-1:0] gpio_oe_in,
   input wire logic [`LED_COUNT-1:0] led_on_in,
   output strap_cfg_t cfg_out,
   output logic cfg_valid_out,
   output logic wake_event_out_n,
   output logic wake_event_oe_out,
   output logic [`GPIO_COUNT-1:0] gpio_out,
   output logic [`GPIO_COUNT-1:0] gpio_oe_out,
   output logic [`LED_COUNT-1:0] led_out,
   output logic [`LED_COUNT-1:0] led_oe_out
);

   // Pin driver as {level, enable}: open-drain only pulls low and lets
   // the board's resistor take the pin high, push-pull always drives
   function automatic logic [1:0] pin_drive(input logic level,
                                            input logic open_drain);
      if (open_drain) begin
         pin_drive = {1'b0, ~level};
      end else begin
         pin_drive = {level, 1'b1};
      end
   endfunction

   // LED pin level: polarity 1 drives high for on, 0 drives low for on
   function automatic logic [`LED_COUNT-1:0] led_level(
      input logic [`LED_COUNT-1:0] on,
      input logic [`LED_COUNT-1:0] polarity);
      led_level = ~(on ^ polarity);
   endfunction

   capture_state_t state;
   strap_bits_t strap_meta;
   strap_bits_t strap_sync;
   logic wake_meta;
   logic wake_sync;
   logic wake_level;
   logic [1:0] wake_drv;
   logic [1:0] next_drv;
   logic [1:0] ded_drv;
   logic route_od;
   logic drive_ok;

   // Strap pins are sampled all through reset, so the synchroniser is
   // already full at release; no reset here on purpose, since a reset
   // would hand zeros to the capture instead of the resistor levels
   always_ff @(posedge clk_in) begin
      if (clk_en_in) begin
         strap_meta <= strap_pins_in;
         strap_sync <= strap_meta;
      end
   end

   // Wake event comes from outside this clock, so two flops first
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end else if (clk_en_in) begin
         wake_meta <= wake_event_in;
         wake_sync <= wake_meta;
      end
   end

   // Sequencer: one edge out of reset, one edge to capture, then run
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_RESET;
      end else if (clk_en_in) begin
         case (state)
            ST_RESET: state <= ST_SAMPLE;
            ST_SAMPLE: state <= ST_RUN;
            ST_RUN: state <= ST_RUN;
            default: state <= ST_RESET;
         endcase
      end
   end

   // Capture once at the second edge after release; async reset loads
   // constants only, so nothing here depends on the pins during reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_out <= '0;
         cfg_out.mgmt_addr <= `RST_MGMT_ADDR;
         cfg_out.led_polarity <= `RST_LED_POL;
         cfg_out.mode <= `RST_MODE;
         cfg_valid_out <= 1'b0;
      end else if (clk_en_in && state == ST_SAMPLE) begin
         cfg_out.jack_presets <= strap_sync.integrated_jack;
         cfg_out.mgmt_addr <= strap_sync.mgmt_addr;
         cfg_out.bcast_addr_enable <= ~strap_sync.broadcast_addr;
         cfg_out.led_polarity <= ~strap_sync.led_active_level;
         cfg_out.ref_clk_enable <= strap_sync.ref_clk_out_enable;
         cfg_out.led_individual <= strap_sync.led_style;
         cfg_out.mode <= strap_sync.mode;
         cfg_valid_out <= 1'b1;
      end
   end

   // Buffer type of the routed pin; selector 7 points at no pin, so the
   // lookup falls back to push-pull instead of reading past the vector
   always_comb begin
      route_od = 1'b0;
      for (int i = 0; i < `GPIO_COUNT; i++) begin
         if (wake_gpio_sel_in == i[`WAKE_SEL_W-1:0]) begin
            route_od = gpio_open_drain_in[i];
         end
      end
   end

   // Pins may drive only once the configuration is held
   assign drive_ok = (state == ST_RUN);

   // Wake level with polarity applied; low-active when polarity is 0
   assign wake_level = wake_polarity_in ? wake_sync : ~wake_sync;
   // Routed pin follows its buffer-type bit
   assign wake_drv = pin_drive(wake_level, route_od);
   // Dedicated pin has no buffer-type bit of its own, so push-pull
   assign ded_drv = pin_drive(wake_level, 1'b0);
   // Dedicated pin stays released unless it carries the wake output
   assign next_drv = (drive_ok && wake_route_dedicated_in) ?
      ded_drv : 2'b00;

   // Dedicated wake pin, quiet until configuration is held
   // A released pin's level is don't-care; only the enable reaches the pad
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wake_event_out_n <= 1'b1;
         wake_event_oe_out <= 1'b0;
      end else if (clk_en_in) begin
         wake_event_out_n <= next_drv[1];
         wake_event_oe_out <= next_drv[0];
      end
   end

   // GPIO pins: the selected one carries the wake output instead
   // of its ordinary drive; the others pass the ordinary drive through
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gpio_out <= '0;
         gpio_oe_out <= '0;
      end else if (clk_en_in) begin
         for (int i = 0; i < `GPIO_COUNT; i++) begin
            if (state != ST_RUN) begin
               gpio_out[i] <= 1'b0;
               gpio_oe_out[i] <= 1'b0;
            end else if (!wake_route_dedicated_in &&
                         wake_gpio_sel_in == i[`WAKE_SEL_W-1:0]) begin
               gpio_out[i] <= wake_drv[1];
               gpio_oe_out[i] <= wake_drv[0];
            end else begin
               gpio_out[i] <= gpio_out_in[i];
               gpio_oe_out[i] <= gpio_oe_in[i];
            end
         end
      end
   end

   // LEDs push-pull with the captured polarity, after straps are held
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         led_out <= '0;
         led_oe_out <= '0;
      end else if (clk_en_in) begin
         if (state == ST_RUN) begin
            led_out <= led_level(led_on_in, cfg_out.led_polarity);
            led_oe_out <= '1;
         end else begin
            led_out <= '0;
            led_oe_out <= '0;
         end
      end
   end

endmodule

// ===== strap_capture_cfg.svh
// Constants for the strap capture and wake output block
`ifndef STRAP_CAPTURE_CFG_SVH
`define STRAP_CAPTURE_CFG_SVH
`define GPIO_COUNT 7
`define LED_COUNT 5
`define MGMT_ADDR_W 3
`define MODE_W 5
`define BCAST_ADDR 3'h0
`define RST_MODE 5'h00
`define RST_MGMT_ADDR 3'h0
`define RST_LED_POL 5'h00
`define WAKE_SEL_W 3
`endif

// ===== strap_capture_pkg.sv
// Types shared by the strap capture and wake output block
`include "strap_capture_cfg.svh"
package strap_capture_pkg;
   typedef struct packed {
      logic integrated_jack;
      logic [`MGMT_ADDR_W-1:0] mgmt_addr;
      logic [`LED_COUNT-1:0] led_active_level;
      logic broadcast_addr;
      logic ref_clk_out_enable;
      logic led_style;
      logic [`MODE_W-1:0] mode;
   } strap_bits_t;
   typedef struct packed {
      logic jack_presets;
      logic [`MGMT_ADDR_W-1:0] mgmt_addr;
      logic bcast_addr_enable;
      logic [`LED_COUNT-1:0] led_polarity;
      logic ref_clk_enable;
      logic led_individual;
      logic [`MODE_W-1:0] mode;
   } strap_cfg_t;
   typedef enum logic [1:0] {
      ST_RESET,
      ST_SAMPLE,
      ST_RUN
   } capture_state_t;
endpackage

// ===== strap_capture_asserts.sv
// Port assertions for the strap capture block
`timescale 1ns/100ps
`include "strap_capture_cfg.svh"
module strap_capture_asserts
   import strap_capture_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire strap_bits_t strap_pins_in,
   input wire logic wake_event_in,
   input wire logic wake_polarity_in,
   input wire logic wake_route_dedicated_in,
   input wire logic [`LED_COUNT-1:0] led_on_in,
   input wire strap_cfg_t cfg_out,
   input wire logic cfg_valid_out,
   input wire logic wake_event_out_n,
   input wire logic wake_event_oe_out,
   input wire logic [`GPIO_COUNT-1:0] gpio_oe_out,
   input wire logic [`LED_COUNT-1:0] led_out,
   input wire logic [`LED_COUNT-1:0] led_oe_out
);
   strap_bits_t s;
   // Short alias keeps the capture check readable
   assign s = strap_pins_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_hold; cfg_valid_out |=> $stable(cfg_out); endproperty
   a_hold: assert property (p_hold) else $error("cfg moved");
   property p_cfg; $rose(cfg_valid_out) |-> cfg_out == {s.integrated_jack,
      s.mgmt_addr, !s.broadcast_addr, ~s.led_active_level,
      s.ref_clk_out_enable, s.led_style, s.mode}; endproperty
   a_cfg: assert property (p_cfg) else $error("cfg bad");
   property p_idle; !cfg_valid_out |-> led_oe_out == 0 &&
      gpio_oe_out == 0 && !wake_event_oe_out; endproperty
   a_idle: assert property (p_idle) else $error("early drive");
   property p_led_on; $rose(cfg_valid_out) && clk_en_in |=>
      led_oe_out == '1; endproperty
   a_led_on: assert property (p_led_on) else $error("led idle");
   property p_led; cfg_valid_out && $past(cfg_valid_out) && $past(clk_en_in)
      |-> led_out == ~($past(led_on_in) ^ cfg_out.led_polarity); endproperty
   a_led: assert property (p_led) else $error("led level");
   property p_won; (cfg_valid_out && wake_route_dedicated_in && clk_en_in &&
      wake_event_in && $stable(wake_polarity_in))[*5] |->
      wake_event_out_n == wake_polarity_in; endproperty
   a_won: assert property (p_won) else $error("wake on");
   property p_woff; (cfg_valid_out && wake_route_dedicated_in && clk_en_in &&
      !wake_event_in && $stable(wake_polarity_in))[*5] |->
      wake_event_out_n != wake_polarity_in; endproperty
   a_woff: assert property (p_woff) else $error("wake off");
   property p_moved; (cfg_valid_out && !wake_route_dedicated_in &&
      clk_en_in)[*3] |-> !wake_event_oe_out; endproperty
   a_moved: assert property (p_moved) else $error("wake pin");
endmodule
bind strap_capture strap_capture_asserts chk (.*);

// ===== strap_board.sv
// Board model: strap resistors on pins shared with the LEDs
`timescale 1ns/100ps
`include "strap_capture_cfg.svh"
module strap_board
   import strap_capture_pkg::*;
(
   input wire strap_bits_t pull_in,
   input wire logic [`LED_COUNT-1:0] led_in,
   input wire logic [`LED_COUNT-1:0] led_oe_in,
   output strap_bits_t pins_out
);
   // A driven LED pin overrides its pull, so late captures would be wrong
   always_comb begin
      pins_out = pull_in;
      pins_out.led_active_level = (led_oe_in & led_in) |
         (~led_oe_in & pull_in.led_active_level);
   end
endmodule

// ===== strap_capture_test.sv
// Self-checking bench for the strap capture block
`timescale 1ns/100ps
`include "strap_capture_cfg.svh"
module strap_capture_test
   import strap_capture_pkg::*;
   ;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic en = 1'h1;
   logic ev, pol, ded, wake_n, wake_oe, valid;
   logic [`WAKE_SEL_W-1:0] sel;
   logic [`GPIO_COUNT-1:0] od, gout, goe, gpio, gpio_oe;
   logic [`LED_COUNT-1:0] led_on, led, led_oe;
   strap_bits_t pull, pins;
   strap_cfg_t cfg;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   // Each row: strap pulls beside the configuration they must produce
   typedef struct packed {
      strap_bits_t pull;
      strap_cfg_t cfg;
   } row_t;
   row_t rows [4] = '{'{17'h0_0000, 17'h0_1F80}, '{17'h1_FFFF, 17'h1_E07F},
      '{17'h0_A5C3, 17'h0_AD43}, '{17'h1_5A3C, 17'h1_52BC}};
   strap_capture dut (.clk_in(clk), .rst_in(rst), .clk_en_in(en),
      .strap_pins_in(pins), .wake_event_in(ev), .wake_polarity_in(pol),
      .wake_route_dedicated_in(ded), .wake_gpio_sel_in(sel),
      .gpio_open_drain_in(od), .gpio_out_in(gout), .gpio_oe_in(goe),
      .led_on_in(led_on), .cfg_out(cfg), .cfg_valid_out(valid),
      .wake_event_out_n(wake_n), .wake_event_oe_out(wake_oe),
      .gpio_out(gpio), .gpio_oe_out(gpio_oe), .led_out(led),
      .led_oe_out(led_oe));
   strap_board board (.pull_in(pull), .led_in(led), .led_oe_in(led_oe),
      .pins_out(pins));
   initial begin
      forever #2 clk = ~clk;
   end
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic complete_run();
      $display("Compared %0d, mismatched %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      {ev, pol, ded, sel, od, gout, goe} = '0;
      led_on = 5'h15;
      foreach (rows[i]) begin
         rst = 1'h1;
         pull = rows[i].pull;
         step(5);
         chk("oe", {led_oe, gpio_oe, wake_oe}, 0);
         rst = 1'h0;
         step(4);
         chk("cfg", cfg, rows[i].cfg);
         chk("valid", valid, 1'h1);
         chk("led", led, led_on ^ rows[i].pull.led_active_level);
         chk("led oe", led_oe, 5'h1f);
         pull = ~rows[i].pull;
         step(3);
         chk("held", cfg, rows[i].cfg);
         $display("Strap row %0d done", i);
      end
      ded = 1'h1;
      for (int p = 0; p < 2; p++) begin
         pol = p[0];
         ev = 1'h1;
         step(5);
         chk("wake on", wake_n, p[0]);
         chk("wake oe", wake_oe, 1'h1);
         ev = 1'h0;
         step(5);
         chk("wake off", wake_n, !p[0]);
      end
      $display("Dedicated wake pin done");
      {ded, pol, od, ev} = {1'h0, 1'h0, 7'h01, 1'h1};
      step(5);
      chk("od on", {gpio_oe[0], gpio[0]}, 2'h2);
      ev = 1'h0;
      step(5);
      chk("od off", gpio_oe[0], 0);
      {sel, pol, ev} = {3'h6, 1'h1, 1'h1};
      step(5);
      chk("pp on", {gpio_oe[6], gpio[6]}, 2'h3);
      {sel, gout, goe} = {3'h7, 7'h55, 7'h0f};
      step(2);
      chk("gpio", {gpio_oe, gpio}, {7'h0f, 7'h55});
      $display("Routed wake pin done");
      // Clock enable low must freeze the wake enable and GPIO outputs, then resume cleanly
      {en, ded, ev} = {1'h0, 1'h1, 1'h0};
      step(5);
      chk("frozen", {wake_oe, gpio_oe, gpio}, {1'h0, 7'h0f, 7'h55});
      en = 1'h1;
      step(5);
      chk("wake oe", wake_oe, 1'h1);
      chk("wake idle", wake_n, 1'h0);
      $display("Clock enable done");
      complete_run();
   end
endmodule
